// >>> bench/bcs_field.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Field side: operator switches and contactors
// ----------------------------------------
module bcs_field
    import bcs_pkg::*;
(
    input wire logic hclk,
    input wire bcs_pins_t sw,
    input wire logic mc_bypass,
    input wire logic mc_output,
    output bcs_pins_t pins,
    output logic clash
);
    // Contacts pass straight through; the block syncs them itself
    assign pins = sw;
    // Both motor contactors closed would short drive output to mains
    always_ff @(posedge hclk) begin
        clash <= mc_bypass && mc_output;
    end
endmodule
`default_nettype wire

// >>> bench/bcs_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module bcs_monitor
    import bcs_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [31:0] hrdata,
    input wire bcs_pins_t pins,
    input wire bcs_drv_t drv,
    input wire logic supply_contactor_drive,
    input wire logic bypass_contactor_drive,
    input wire logic output_contactor_drive
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    property p_no_both;
        !(bypass_contactor_drive && output_contactor_drive);
    endproperty
    property p_byp_after_out;
        $rose(bypass_contactor_drive) |->
            !$past(output_contactor_drive) && !$past(output_contactor_drive, 2);
    endproperty
    property p_out_after_byp;
        $rose(output_contactor_drive) |->
            !$past(bypass_contactor_drive) && !$past(bypass_contactor_drive, 2);
    endproperty
    property p_fault_drop;
        drv.fault |-> ##[1:4] !supply_contactor_drive;
    endproperty
    // Sync stages plus contactor output flops fit in five cycles
    property p_thermal;
        (!pins.thermal_ok)[*5] |-> !supply_contactor_drive &&
            !bypass_contactor_drive && !output_contactor_drive;
    endproperty
    property p_no_permit;
        (!pins.permit)[*6] |-> !bypass_contactor_drive;
    endproperty
    property p_bus_ok;
        hreadyout && !hresp;
    endproperty
    property p_rdata_hold;
        !(hsel && htrans[1] && hready && !hwrite) |=> $stable(hrdata);
    endproperty
    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    a_no_both: assert property (p_no_both)
        else $error("bypass and output contactors closed together");
    a_byp_after_out: assert property (p_byp_after_out)
        else $error("bypass closed too soon after output");
    a_out_after_byp: assert property (p_out_after_byp)
        else $error("output closed too soon after bypass");
    a_fault_drop: assert property (p_fault_drop)
        else $error("supply contactor held through fault");
    a_thermal: assert property (p_thermal)
        else $error("contactor closed with thermal abnormal");
    a_no_permit: assert property (p_no_permit)
        else $error("bypass closed without permit");
    a_bus_ok: assert property (p_bus_ok)
        else $error("bus not ready or error response");
    a_rdata_hold: assert property (p_rdata_hold)
        else $error("read data moved without read");
    c_byp: cover property ($rose(bypass_contactor_drive));
    c_out: cover property ($rose(output_contactor_drive));
    c_fault: cover property ($fell(supply_contactor_drive));
endmodule
bind bcs_top bcs_monitor i_mon (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans),
    .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .pins(pins), .drv(drv),
    .supply_contactor_drive(supply_contactor_drive),
    .bypass_contactor_drive(bypass_contactor_drive),
    .output_contactor_drive(output_contactor_drive)
);
`default_nettype wire

// >>> bench/tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "bcs_map.svh"
module tb;
    import bcs_pkg::*;
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata, r;
    logic [1:0] htrans;
    logic [2:0] hsize, term;
    logic sup, byp, outc, run_ok, ilk, act, clash;
    bcs_pins_t sw, pins;
    bcs_drv_t drv;
    int bad_count, compares;
    // Short tick keeps the switch waits to a few cycles
    bcs_top #(.TICK_CYC(4), .NTERM(3)) i_dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .pins(pins), .drv(drv),
        .supply_contactor_drive(sup), .bypass_contactor_drive(byp),
        .output_contactor_drive(outc), .term_out(term),
        .drive_run_ok(run_ok), .panel_interlock_out(ilk), .seq_active(act)
    );
    bcs_field i_field (.hclk(hclk), .sw(sw), .mc_bypass(byp),
        .mc_output(outc), .pins(pins), .clash(clash));
    initial begin
        hclk = 1'b0;
        forever #2 hclk = ~hclk;
    end
    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic end_sim;
        $display("compares %0d, mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] seen,
        input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask
    // One single transfer; both phases held until ready is seen
    task automatic bus(input logic wr, input logic [31:0] a,
        input logic [31:0] wd);
        int n;
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= wr;
        n = 0;
        do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 50);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= wd;
        do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 99);
        r = hrdata;
        if (n >= 99) begin
            chk("bus timeout", 32'h1, 32'h0);
            end_sim;
        end
    endtask
    task automatic rdchk(input logic [31:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk("register", r, exp);
    endtask
    // Contactor triple is {supply, bypass, output}
    task automatic wait_k(input logic [2:0] exp);
        int n;
        n = 0;
        while ({sup, byp, outc} !== exp && n < 400) begin
            @(posedge hclk);
            n++;
        end
        chk("contactors", {29'h0, sup, byp, outc}, {29'h0, exp});
        if (n >= 400) end_sim;
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge hclk);
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_regs;
        rdchk(`BCS_OFS_CTRL, `BCS_CTRL_RST);
        rdchk(`BCS_OFS_WAIT, `BCS_WAIT_RST);
        rdchk(`BCS_OFS_FREQ, `BCS_FREQ_RST);
        rdchk(`BCS_OFS_TERM, `BCS_TERM_RST);
        // Unmapped place swallows writes and reads as zero
        bus(1'b1, 32'h14, 32'hFFFFFFFF);
        rdchk(32'h14, 32'h0);
        $display("test regs done");
    endtask
    task automatic t_seq;
        bus(1'b1, `BCS_OFS_CTRL, 32'h31);
        bus(1'b1, `BCS_OFS_WAIT, 32'h0001_0001);
        bus(1'b1, `BCS_OFS_TERM, 32'h0013_1211);
        sw.thermal_ok <= 1'b1;
        sw.permit <= 1'b1;
        sw.select <= 1'b1;
        sw.fwd <= 1'b1;
        wait_k(3'h5);
        idle(3);
        chk("term", {29'h0, term}, 32'h5);
        chk("run_ok", {31'h0, run_ok}, 32'h1);
        chk("seq_active", {31'h0, act}, 32'h1);
        sw.select <= 1'b0;
        wait_k(3'h6);
        idle(3);
        chk("term", {29'h0, term}, 32'h3);
        bus(1'b0, `BCS_OFS_STAT, 32'h0);
        chk("state", {30'h0, r[2:1]}, 32'h3);
        sw.select <= 1'b1;
        wait_k(3'h5);
        sw.fwd <= 1'b0;
        idle(30);
        wait_k(3'h5);
        chk("run_ok", {31'h0, run_ok}, 32'h0);
        sw.permit <= 1'b0;
        sw.select <= 1'b0;
        idle(30);
        wait_k(3'h5);
        sw.permit <= 1'b1;
        wait_k(3'h6);
        sw.fwd <= 1'b1;
        idle(30);
        wait_k(3'h6);
        chk("run_ok", {31'h0, run_ok}, 32'h0);
        $display("test sequence done");
    endtask
    task automatic t_fault;
        drv.fault <= 1'b1;
        @(posedge hclk);
        drv.fault <= 1'b0;
        wait_k(3'h0);
        sw.init <= 1'b1;
        idle(8);
        sw.init <= 1'b0;
        wait_k(3'h6);
        sw.thermal_ok <= 1'b0;
        wait_k(3'h0);
        sw.thermal_ok <= 1'b1;
        wait_k(3'h6);
        // Bypass was left by a coast, so the next drive start waits
        sw.select <= 1'b1;
        wait_k(3'h5);
        chk("run_ok", {31'h0, run_ok}, 32'h0);
        idle(12);
        chk("run_ok", {31'h0, run_ok}, 32'h1);
        $display("test fault done");
    endtask
    // Switch 100, return range 10: back to drive below 90
    task automatic t_auto;
        drv.out_freq <= 14'h0064;
        drv.freq_cmd <= 14'h0064;
        bus(1'b1, `BCS_OFS_FREQ, 32'h000A_0064);
        wait_k(3'h6);
        drv.out_freq <= 14'h0000;
        drv.freq_cmd <= 14'h0050;
        wait_k(3'h5);
        bus(1'b1, `BCS_OFS_FREQ, `BCS_FREQ_RST);
        $display("test auto done");
    endtask
    task automatic t_direct;
        // Enabled outside mode 3 just closes supply and output
        bus(1'b1, `BCS_OFS_CTRL, 32'h01);
        sw.permit <= 1'b0;
        wait_k(3'h5);
        idle(3);
        chk("seq_active", {31'h0, act}, 32'h0);
        chk("run_ok", {31'h0, run_ok}, 32'h1);
        // Interlock mode without a dedicated input borrows permit
        bus(1'b1, `BCS_OFS_CTRL, 32'h71);
        sw.permit <= 1'b1;
        idle(5);
        chk("interlock", {31'h0, ilk}, 32'h1);
        bus(1'b1, `BCS_OFS_CTRL, 32'h271);
        idle(3);
        chk("interlock", {31'h0, ilk}, 32'h0);
        $display("test direct done");
    endtask
    initial begin
        sw = '0;
        drv = '0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        bad_count = 0;
        compares = 0;
        hresetn = 1'b0;
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        t_regs;
        t_seq;
        t_fault;
        t_auto;
        t_direct;
        chk("clash", {31'h0, clash}, 32'h0);
        end_sim;
    end
endmodule
`default_nettype wire

// >>> src/bcs_map.svh
`ifndef BCS_MAP_SVH
`define BCS_MAP_SVH
// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define BCS_OFS_CTRL 8'h00
`define BCS_OFS_WAIT 8'h04
`define BCS_OFS_FREQ 8'h08
`define BCS_OFS_TERM 8'h0C
`define BCS_OFS_STAT 8'h10
// ----------------------------------------
// Control fields
// ----------------------------------------
`define BCS_CTRL_ENA 0
`define BCS_CTRL_MODE_LO 4
`define BCS_CTRL_FBYP 8
`define BCS_CTRL_ILK 9
`define BCS_CTRL_RST 32'h0000_0010
// ----------------------------------------
// Wait, frequency and terminal fields
// ----------------------------------------
`define BCS_WAIT_SW_LO 0
`define BCS_WAIT_ST_LO 16
`define BCS_WAIT_RST 32'h0005_0000
`define BCS_FREQ_SW_LO 0
`define BCS_FREQ_RR_LO 16
`define BCS_FREQ_RST 32'h270F_270F
`define BCS_TERM_RST 32'h0000_0000
// ----------------------------------------
// Setting values
// ----------------------------------------
`define BCS_SEQ_ON 1
`define BCS_MODE_EXT 4'h3
`define BCS_MODE_PANEL 4'h1
`define BCS_MODE_ILK 4'h7
`define BCS_FREQ_OFF 14'h270F
`define BCS_FN_SUPPLY 5'h11
`define BCS_FN_BYPASS 5'h12
`define BCS_FN_OUTPUT 5'h13
// ----------------------------------------
// Timing: waits count in ticks of 100 ms
// ----------------------------------------
`define BCS_TICK_MS 100
`define BCS_CLK_MHZ 250
`define BCS_TICK_CYC (`BCS_TICK_MS * `BCS_CLK_MHZ * 1000)
`endif

// >>> src/bcs_pkg.sv
package bcs_pkg;
    // Raw pin group from the operator or PLC switches
    typedef struct packed {
        logic permit;
        logic select;
        logic fwd;
        logic rev;
        logic thermal_ok;
        logic init;
        logic interlock;
    } bcs_pins_t;
    // Drive status from logic on the same clock
    typedef struct packed {
        logic fault;
        logic fault_no_bypass;
        logic [13:0] out_freq;
        logic [13:0] freq_cmd;
    } bcs_drv_t;
    typedef enum logic [1:0] {
        T_HOLD, T_OFF, T_DRV, T_BYP
    } bcs_tgt_t;
    typedef enum logic [1:0] {
        ST_OFF, ST_SETTLE, ST_DRIVE, ST_BYPASS
    } bcs_state_t;
endpackage

// >>> src/bcs_top.sv
// The placing of the registers and the AHB-Lite slave port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "bcs_map.svh"

module bcs_top
    import bcs_pkg::*;
#(
    parameter int TICK_CYC = `BCS_TICK_CYC,
    parameter int NTERM = 3
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire bcs_pins_t pins,
    input wire bcs_drv_t drv,
    output logic supply_contactor_drive,
    output logic bypass_contactor_drive,
    output logic output_contactor_drive,
    output logic [NTERM-1:0] term_out,
    output logic drive_run_ok,
    output logic panel_interlock_out,
    output logic seq_active
);

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    bcs_pins_t pin_meta;
    bcs_pins_t pin_s;

    // Switches are asynchronous to hclk
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pin_meta <= '0;
            pin_s <= '0;
        end else begin
            pin_meta <= pins;
            pin_s <= pin_meta;
        end
    end

    // ----------------------------------------
    // Bus slave
    // ----------------------------------------
    logic [31:0] reg_ctrl;
    logic [31:0] reg_wait;
    logic [31:0] reg_freq;
    logic [31:0] reg_term;
    logic [31:0] stat_word;
    logic wr_pend;
    logic [7:0] wr_addr;
    logic addr_ok;
    logic [31:0] rd_mux;

    // Address phase accepted only on a real transfer
    assign addr_ok = hsel & htrans[1] & hready;

    // Writes land in the data phase; hsize is always a word here
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend <= 1'b0;
            wr_addr <= 8'h00;
        end else begin
            wr_pend <= addr_ok & hwrite;
            wr_addr <= haddr[7:0];
        end
    end

    // Zero wait state, always OKAY
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

    // Register writes; unmapped offsets are dropped
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            reg_ctrl <= `BCS_CTRL_RST;
            reg_wait <= `BCS_WAIT_RST;
            reg_freq <= `BCS_FREQ_RST;
            reg_term <= `BCS_TERM_RST;
        end else if (wr_pend) begin
            case (wr_addr)
                `BCS_OFS_CTRL: reg_ctrl <= hwdata;
                `BCS_OFS_WAIT: reg_wait <= hwdata;
                `BCS_OFS_FREQ: reg_freq <= hwdata;
                `BCS_OFS_TERM: reg_term <= hwdata;
                default: ;
            endcase
        end
    end

    // Read mux; unmapped reads return zero
    always_comb begin
        case (haddr[7:0])
            `BCS_OFS_CTRL: rd_mux = reg_ctrl;
            `BCS_OFS_WAIT: rd_mux = reg_wait;
            `BCS_OFS_FREQ: rd_mux = reg_freq;
            `BCS_OFS_TERM: rd_mux = reg_term;
            `BCS_OFS_STAT: rd_mux = stat_word;
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    // Read data sampled at the address phase, stands in data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (addr_ok & ~hwrite) begin
            hrdata <= rd_mux;
        end
    end

    // ----------------------------------------
    // Setting fields
    // ----------------------------------------
    logic seq_en;
    logic [3:0] mode;
    logic fault_bypass;
    logic ilk_assigned;
    logic [7:0] sw_wait;
    logic [7:0] st_wait;
    logic [13:0] sw_freq;
    logic [13:0] ret_range;
    logic seq_mode;
    logic direct_mode;
    logic auto_on;

    assign seq_en = reg_ctrl[`BCS_CTRL_ENA];
    assign mode = reg_ctrl[`BCS_CTRL_MODE_LO +: 4];
    assign fault_bypass = reg_ctrl[`BCS_CTRL_FBYP];
    assign ilk_assigned = reg_ctrl[`BCS_CTRL_ILK];
    assign sw_wait = reg_wait[`BCS_WAIT_SW_LO +: 8];
    assign st_wait = reg_wait[`BCS_WAIT_ST_LO +: 8];
    assign sw_freq = reg_freq[`BCS_FREQ_SW_LO +: 14];
    assign ret_range = reg_freq[`BCS_FREQ_RR_LO +: 14];
    // Full sequence only in external/combined mode
    assign seq_mode = seq_en & (mode == `BCS_MODE_EXT);
    // Any other mode: supply and output simply on, no waits
    assign direct_mode = seq_en & ~seq_mode;
    assign auto_on = seq_mode & (sw_freq != `BCS_FREQ_OFF);

    // ----------------------------------------
    // Tick divider for the programmable waits
    // ----------------------------------------
    logic [31:0] div_cnt;
    logic tick;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            div_cnt <= 32'h0000_0000;
            tick <= 1'b0;
        end else if (div_cnt >= 32'(TICK_CYC - 1)) begin
            div_cnt <= 32'h0000_0000;
            tick <= 1'b1;
        end else begin
            div_cnt <= div_cnt + 32'h0000_0001;
            tick <= 1'b0;
        end
    end

    // ----------------------------------------
    // Fault latch
    // ----------------------------------------
    logic fault_q;
    logic fault_nb_q;
    logic run_cmd;
    logic thermal_bad;

    assign run_cmd = pin_s.fwd | pin_s.rev;
    assign thermal_bad = ~pin_s.thermal_ok;

    // Held until status initialise; a new fault wins over the clear
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            fault_q <= 1'b0;
            fault_nb_q <= 1'b0;
        end else if (drv.fault) begin
            fault_q <= 1'b1;
            fault_nb_q <= fault_nb_q | drv.fault_no_bypass;
        end else if (pin_s.init) begin
            fault_q <= 1'b0;
            fault_nb_q <= 1'b0;
        end
    end

    // ----------------------------------------
    // Automatic switchover by frequency
    // ----------------------------------------
    // State is read by the switchover latch, so it is declared first
    bcs_state_t state;
    bcs_state_t next_state;
    logic auto_byp;
    logic [14:0] ret_level;
    logic ret_hit;

    // Guard against underflow when range exceeds switch frequency
    assign ret_level = {1'b0, sw_freq} - {1'b0, ret_range};
    assign ret_hit = (ret_range != `BCS_FREQ_OFF) & ~ret_level[14]
        & ({1'b0, drv.freq_cmd} < ret_level);

    // Set while driving at or above switch frequency
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            auto_byp <= 1'b0;
        end else if (~auto_on | ~run_cmd | ~pin_s.permit
            | ~pin_s.select) begin
            auto_byp <= 1'b0;
        end else if (state == ST_DRIVE
            && drv.out_freq >= sw_freq) begin
            auto_byp <= 1'b1;
        end else if (auto_byp & ret_hit) begin
            auto_byp <= 1'b0;
        end
    end

    // ----------------------------------------
    // Target selection
    // ----------------------------------------
    bcs_tgt_t tgt;

    always_comb begin
        tgt = T_OFF;
        if (!seq_en) begin
            tgt = T_OFF;
        end else if (thermal_bad) begin
            tgt = T_OFF;
        end else if (fault_q) begin
            // Excluded faults never move to bypass
            tgt = (fault_bypass & ~fault_nb_q) ? T_BYP : T_OFF;
        end else if (direct_mode) begin
            tgt = T_DRV;
        end else if (pin_s.init) begin
            // Bypass drops, output contactor unchanged
            tgt = (state == ST_DRIVE) ? T_HOLD : T_OFF;
        end else if (!pin_s.permit) begin
            // Select and run ignored; output contactor unchanged
            tgt = (state == ST_DRIVE) ? T_HOLD : T_OFF;
        end else if (!pin_s.select) begin
            tgt = T_BYP;
        end else if (auto_byp) begin
            tgt = T_BYP;
        end else begin
            // Run on or off, output contactor stays closed
            tgt = T_DRV;
        end
    end

    // ----------------------------------------
    // Contactor sequencer
    // ----------------------------------------
    logic [7:0] sw_cnt;
    logic sw_done;

    // Panel and other modes skip the switch wait
    assign sw_done = ~seq_mode | (sw_cnt >= sw_wait);

    always_comb begin
        next_state = state;
        case (state)
            ST_OFF: begin
                if (tgt == T_DRV || tgt == T_BYP) begin
                    next_state = ST_SETTLE;
                end
            end
            ST_SETTLE: begin
                if (tgt == T_OFF || tgt == T_HOLD) begin
                    next_state = ST_OFF;
                end else if (sw_done) begin
                    next_state = (tgt == T_DRV) ? ST_DRIVE : ST_BYPASS;
                end
            end
            ST_DRIVE: begin
                // Open output first, motor coasts before bypass
                if (tgt == T_BYP || tgt == T_OFF) begin
                    next_state = ST_OFF;
                end
            end
            ST_BYPASS: begin
                // Open bypass first, motor coasts before drive
                if (tgt != T_BYP) begin
                    next_state = ST_OFF;
                end
            end
            default: next_state = ST_OFF;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state <= ST_OFF;
        end else begin
            state <= next_state;
        end
    end

    // Switch wait counter, restarts on entry to settle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sw_cnt <= 8'h00;
        end else if (state != ST_SETTLE) begin
            sw_cnt <= 8'h00;
        end else if (tick && sw_cnt != 8'hFF) begin
            sw_cnt <= sw_cnt + 8'h01;
        end
    end

    // ----------------------------------------
    // Start wait after coasting from bypass
    // ----------------------------------------
    logic coasted;
    logic [7:0] st_cnt;

    // Bypass left without a drive target means a coast to stop
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            coasted <= 1'b0;
        end else if (state == ST_BYPASS && tgt != T_BYP
            && tgt != T_DRV) begin
            coasted <= 1'b1;
        end else if (~seq_mode
            || (state == ST_DRIVE && st_cnt >= st_wait)) begin
            coasted <= 1'b0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_cnt <= 8'h00;
        end else if (state != ST_DRIVE || !coasted) begin
            st_cnt <= 8'h00;
        end else if (tick && st_cnt != 8'hFF) begin
            st_cnt <= st_cnt + 8'h01;
        end
    end

    // ----------------------------------------
    // Contactor outputs
    // ----------------------------------------
    logic next_sup;

    // Supply opens on fault or thermal trip; recloses on init after a fault, or once thermal_ok returns after a trip
    assign next_sup = seq_en & ~fault_q & ~thermal_bad;

    // Driven from next_state so both close states stay exclusive
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            supply_contactor_drive <= 1'b0;
            bypass_contactor_drive <= 1'b0;
            output_contactor_drive <= 1'b0;
        end else begin
            supply_contactor_drive <= next_sup;
            bypass_contactor_drive <= (next_state == ST_BYPASS);
            output_contactor_drive <= (next_state == ST_DRIVE);
        end
    end

    // Drive may run only after any pending start wait
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            drive_run_ok <= 1'b0;
        end else begin
            drive_run_ok <= (next_state == ST_DRIVE) & run_cmd
                & (direct_mode | (pin_s.permit & pin_s.select
                & ~coasted));
        end
    end

    // ----------------------------------------
    // Terminal routing and misc status
    // ----------------------------------------
    logic [2:0] ctc;

    assign ctc = {output_contactor_drive, bypass_contactor_drive,
        supply_contactor_drive};

    genvar gi;
    generate
        for (gi = 0; gi < NTERM; gi++) begin : g_term
            logic [4:0] fn;
            assign fn = reg_term[gi*8 +: 5];
            // Lag of one cycle behind the contactor flops
            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    term_out[gi] <= 1'b0;
                end else begin
                    case (fn)
                        `BCS_FN_SUPPLY: term_out[gi] <= ctc[0];
                        `BCS_FN_BYPASS: term_out[gi] <= ctc[1];
                        `BCS_FN_OUTPUT: term_out[gi] <= ctc[2];
                        default: term_out[gi] <= 1'b0;
                    endcase
                end
            end
        end
    endgenerate

    // In interlock mode (mode 7), permit doubles as interlock when none is assigned
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            panel_interlock_out <= 1'b0;
            seq_active <= 1'b0;
        end else begin
            panel_interlock_out <= (seq_en && mode == `BCS_MODE_ILK
                && !ilk_assigned) ? pin_s.permit
                : pin_s.interlock;
            seq_active <= seq_mode;
        end
    end

    // Status: state, contactors, flags
    assign stat_word = {22'h000000, auto_byp, coasted, fault_nb_q,
        fault_q, ctc, state[1:0], seq_mode};

endmodule
`default_nettype wire
